//--- bench/pbap_assertions.sv
// link-level assertions of the address phase
`timescale 1ns/1ps
module pbap_assertions (
    input wire logic CLK_SYS_I, // system clock
    input wire logic RSTN_I, // sync reset, active low
    input wire logic [pbap_pkg::ALINE_W-1:0] aline, // address/type lines
    input wire logic [pbap_pkg::REQ_W-1:0] req, // request lines
    input wire logic address_valid_strobe, // transaction valid
    input wire logic [1:0] address_phase_strobes, // source strobes
    input wire logic bus_clk // link clock
);
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RSTN_I);
    strb_pair_a: assert property (
        address_phase_strobes[1] == address_phase_strobes[0])
        else $error("strobes split");
    rise_in_valid_a: assert property (
        $rose(address_phase_strobes[0]) |-> address_valid_strobe)
        else $error("strobe rise outside valid");
    fall_in_valid_a: assert property (
        $fell(address_phase_strobes[0]) |-> address_valid_strobe)
        else $error("strobe fall outside valid");
    line_hold_a: assert property (
        $changed(address_phase_strobes[0]) |-> $stable(aline))
        else $error("lines move with strobe");
    valid_min_a: assert property (
        $rose(address_valid_strobe) |-> address_valid_strobe [*8])
        else $error("valid too short");
    valid_end_a: assert property (
        $rose(address_valid_strobe) |-> ##[9:24] !address_valid_strobe)
        else $error("valid too long");
    clk_half_a: assert property (
        $rose(bus_clk) |-> bus_clk [*4] ##1 !bus_clk)
        else $error("bus clock half period wrong");
    idle_quiet_a: assert property (
        !address_valid_strobe |-> address_phase_strobes == 2'h0)
        else $error("strobes active while idle");
endmodule : pbap_assertions

//--- bench/test_processor_bus_address_phase.sv
// bench: requester and observer joined over the link
`timescale 1ns/1ps
module test_processor_bus_address_phase;
    logic clk, rstn, mask, start, ready, tv;
    logic [pbap_pkg::CFG_W-1:0] strap, cfg;
    pbap_pkg::pbap_addr_t addr, lookup, taddr;
    logic [pbap_pkg::ALINE_W-1:0] ttype, ttyp;
    logic [pbap_pkg::REQ_W-1:0] req, treq;
    int err_count = 0, num_checks = 0, total = 0, seen = 0;
    pbap_if u_pbap_if ();
    pbap_requester u_pbap_requester (.CLK_SYS_I(clk), .RSTN_I(rstn),
        .bus(u_pbap_if.requester), .ADDRESS_BIT20_MASK_I(mask),
        .STRAP_I(strap), .START_I(start), .ADDR_I(addr), .TYPE_I(ttype),
        .REQ_I(req), .READY_O(ready), .CFG_O(cfg), .LOOKUP_ADDR_O(lookup));
    pbap_observer u_pbap_observer (.CLK_SYS_I(clk), .RSTN_I(rstn),
        .bus(u_pbap_if.observer), .TXN_VALID_O(tv), .TXN_ADDR_O(taddr),
        .TXN_TYPE_O(ttyp), .TXN_REQ_O(treq));
    pbap_assertions u_pbap_assertions (.CLK_SYS_I(clk), .RSTN_I(rstn),
        .aline(u_pbap_if.aline), .req(u_pbap_if.req),
        .address_valid_strobe(u_pbap_if.address_valid_strobe),
        .address_phase_strobes(u_pbap_if.address_phase_strobes),
        .bus_clk(u_pbap_if.bus_clk));
    // ----
    // tasks
    // ----
    initial begin
        clk = 1'h0;
        forever #(pbap_pkg::CLK_NS / 2) clk = ~clk;
    end
    always @(posedge clk) begin
        if (tv === 1'h1) begin
            seen <= seen + 1;
        end
    end
    task automatic chk_val(input string s, input logic [35:0] e, g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask : chk_val
    task automatic chk_flag(input string s, input logic e, g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %b got %b", s, e, g);
        end
    endtask : chk_flag
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic run_txn(input pbap_pkg::pbap_addr_t a, input logic m,
            input logic [4:0] r);
        pbap_pkg::pbap_addr_t e, l;
        int n;
        l = a;
        if (m) begin
            l[pbap_pkg::MASK_BIT] = 1'h0;
        end
        e = {l[35:3], 3'h0};
        mask = m;
        addr = a;
        ttype = ~a[35:3];
        req = r;
        repeat (3) @(negedge clk);
        chk_val("lookup", l, lookup);
        n = 0;
        while (ready !== 1'h1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk_flag("ready", 1'h1, ready);
        start = 1'h1;
        @(negedge clk);
        start = 1'h0;
        repeat (4) @(negedge clk);
        chk_flag("busy", 1'h0, ready);
        start = 1'h1;
        @(negedge clk);
        start = 1'h0;
        n = 0;
        while (tv !== 1'h1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk_flag("txn valid", 1'h1, tv);
        chk_val("txn addr", e, taddr);
        chk_val("txn type", {3'h0, ~a[35:3]}, {3'h0, ttyp});
        chk_val("txn req", {31'h0, r}, {31'h0, treq});
        total++;
    endtask : run_txn
    initial begin
        rstn = 1'h0;
        start = 1'h0;
        mask = 1'h0;
        strap = 8'hA5;
        addr = '0;
        ttype = '0;
        req = '0;
        repeat (4) @(negedge clk);
        rstn = 1'h1;
        @(negedge clk);
        strap = 8'h3C;
        @(negedge clk);
        chk_val("config", 36'hA5, {28'h0, cfg});
        run_txn(36'h8_1234_5678, 1'h0, 5'h01);
        run_txn(36'h8_1234_5678, 1'h1, 5'h1F);
        run_txn(36'h0_0010_FFF8, 1'h1, 5'h0A);
        run_txn(36'hF_FFFF_FFFF, 1'h0, 5'h15);
        rstn = 1'h0;
        repeat (4) @(negedge clk);
        rstn = 1'h1;
        @(negedge clk);
        strap = 8'h5A;
        @(negedge clk);
        chk_val("config again", 36'h3C, {28'h0, cfg});
        run_txn(36'h0_0000_0008, 1'h0, 5'h00);
        repeat (2) @(negedge clk);
        chk_val("txn count", 36'(total), 36'(seen));
        stop_test();
    end
    initial begin
        #(pbap_pkg::CLK_NS * 4000);
        err_count++;
        stop_test();
    end
endmodule : test_processor_bus_address_phase

//--- verilog/pbap_if.sv
// link between requesting agent and observing agent
`timescale 1ns/1ps
interface pbap_if;
    logic [pbap_pkg::ALINE_W-1:0] aline;
    logic [pbap_pkg::REQ_W-1:0] req;
    logic address_valid_strobe;
    logic [1:0] address_phase_strobes;
    logic bus_clk;
    modport requester (
        output aline, req, address_valid_strobe, address_phase_strobes,
        input bus_clk
    );
    modport observer (
        input aline, req, address_valid_strobe, address_phase_strobes,
        output bus_clk
    );
endinterface : pbap_if

//--- verilog/pbap_observer.sv
// observing agent: makes bus clock, captures address phase on strobes
`timescale 1ns/1ps
module pbap_observer (
    input wire logic CLK_SYS_I, // system clock
    input wire logic RSTN_I, // sync reset, active low
    pbap_if.observer bus, // link
    output logic TXN_VALID_O, // one-cycle pulse: new transaction
    output pbap_pkg::pbap_addr_t TXN_ADDR_O, // captured address
    output logic [pbap_pkg::ALINE_W-1:0] TXN_TYPE_O, // sub-phase 2 lines
    output logic [pbap_pkg::REQ_W-1:0] TXN_REQ_O // request lines
);
    localparam int DIV_W = pbap_pkg::LINK_HALF_CYC;
    localparam logic [DIV_W-1:0] DIV_LAST =
        DIV_W'(pbap_pkg::LINK_HALF_CYC - 1);
    logic [DIV_W-1:0] div_reg;
    logic bclk_reg;
    logic [1:0] s2_reg;
    logic [1:0] st0_reg, st1_reg;
    logic v0_reg, v1_reg;
    logic [1:0] phase_reg;
    logic [pbap_pkg::ALINE_W-1:0] a0_reg, a1_reg, asamp_reg;
    logic [pbap_pkg::REQ_W-1:0] r0_reg, r1_reg;
    logic edge_any;
    // ----------------------------------------------
    // bus clock divider
    // ----------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            div_reg <= '0;
            bclk_reg <= 1'b0;
        end else if (div_reg == DIV_LAST) begin
            div_reg <= '0;
            bclk_reg <= ~bclk_reg;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end
    assign bus.bus_clk = bclk_reg;
    // ----------------------------------------------
    // synchronisers
    // ----------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            st0_reg <= 2'h0;
            st1_reg <= 2'h0;
            s2_reg <= 2'h0;
            v0_reg <= 1'b0;
            v1_reg <= 1'b0;
            a0_reg <= pbap_pkg::ALINE_RST;
            a1_reg <= pbap_pkg::ALINE_RST;
            r0_reg <= '0;
            r1_reg <= '0;
        end else begin
            st0_reg <= bus.address_phase_strobes;
            st1_reg <= st0_reg;
            s2_reg <= st1_reg;
            v0_reg <= bus.address_valid_strobe;
            v1_reg <= v0_reg;
            a0_reg <= bus.aline;
            a1_reg <= a0_reg;
            r0_reg <= bus.req;
            r1_reg <= r0_reg;
        end
    end
    // either edge of strobe 0 marks one transfer, strobe 1 moves with it
    assign edge_any = st1_reg[0] ^ s2_reg[0];
    // ----------------------------------------------
    // capture: rise = address, fall = type
    // ----------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            phase_reg <= 2'h0;
            asamp_reg <= pbap_pkg::ALINE_RST;
            TXN_VALID_O <= 1'b0;
            TXN_ADDR_O <= '0;
            TXN_TYPE_O <= '0;
            TXN_REQ_O <= '0;
        end else begin
            TXN_VALID_O <= 1'b0;
            if (v1_reg && edge_any && phase_reg == 2'h0) begin
                asamp_reg <= a1_reg;
                TXN_REQ_O <= r1_reg;
                phase_reg <= 2'h1;
            end else if (edge_any && phase_reg == 2'h1) begin
                TXN_ADDR_O <= {asamp_reg, 3'h0};
                TXN_TYPE_O <= a1_reg;
                TXN_VALID_O <= 1'b1;
                phase_reg <= 2'h0;
            end
        end
    end
endmodule : pbap_observer

//--- verilog/pbap_pkg.sv
// shared constants and types of the processor bus address phase
package pbap_pkg;
    localparam int ADDR_W = 36;
    localparam int ALINE_LSB = 3;
    localparam int ALINE_W = 33;
    localparam int REQ_W = 5;
    localparam int MASK_BIT = 20;
    localparam int STB0_HI = 16;
    localparam int STB1_LO = 17;
    localparam int CFG_LSB = 3;
    localparam int CFG_W = 8;
    localparam int CLK_NS = 50;
    localparam int LINK_HALF_NS = 200;
    localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [ALINE_W-1:0] ALINE_RST = 33'h000000000;
    localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
    typedef logic [ADDR_W-1:0] pbap_addr_t;
endpackage : pbap_pkg

//--- verilog/pbap_requester.sv
// requesting agent: drives address phase, applies address bit 20 mask
`timescale 1ns/1ps
module pbap_requester (
    input wire logic CLK_SYS_I, // system clock
    input wire logic RSTN_I, // sync reset, active low
    pbap_if.requester bus, // link
    input wire logic ADDRESS_BIT20_MASK_I, // async mask input
    input wire logic [pbap_pkg::CFG_W-1:0] STRAP_I, // config straps on lines
    input wire logic START_I, // request a transaction
    input wire pbap_pkg::pbap_addr_t ADDR_I, // physical byte address
    input wire logic [pbap_pkg::ALINE_W-1:0] TYPE_I, // sub-phase 2 info
    input wire logic [pbap_pkg::REQ_W-1:0] REQ_I, // request lines
    output logic READY_O, // idle, may take START_I
    output logic [pbap_pkg::CFG_W-1:0] CFG_O, // power-on configuration
    output pbap_pkg::pbap_addr_t LOOKUP_ADDR_O // masked cache lookup address
);
    typedef enum {ST_IDLE, ST_WAIT, ST_ADDR, ST_TYPE, ST_END} pbap_st_t;
    pbap_st_t st_reg;
    logic m0_reg;
    logic m1_reg;
    logic c0_reg;
    logic c1_reg;
    logic c2_reg;
    logic [pbap_pkg::CFG_W-1:0] strap0_reg;
    logic [pbap_pkg::CFG_W-1:0] strap1_reg;
    logic rst_d_reg;
    pbap_pkg::pbap_addr_t addr_reg;
    pbap_pkg::pbap_addr_t lookup_reg;
    logic [pbap_pkg::ALINE_W-1:0] type_reg;
    logic [pbap_pkg::ALINE_W-1:0] aline_reg;
    logic [pbap_pkg::REQ_W-1:0] req_reg;
    logic ads_reg;
    logic [1:0] stb_reg;
    logic clk_rise;
    logic take;
    logic addr_launch;
    logic type_launch;

    // clear bit 20 when the synchronised mask is set
    function automatic pbap_pkg::pbap_addr_t mask_a20(
        input pbap_pkg::pbap_addr_t a,
        input logic m
    );
        pbap_pkg::pbap_addr_t r;
        r = a;
        if (m) begin
            r[pbap_pkg::MASK_BIT] = 1'b0;
        end
        return r;
    endfunction : mask_a20
    // ----------------------------------------------
    // synchronisers and bus clock edge
    // ----------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            m0_reg <= 1'b0;
            m1_reg <= 1'b0;
        end else begin
            m0_reg <= ADDRESS_BIT20_MASK_I;
            m1_reg <= m0_reg;
        end
    end
    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            c0_reg <= 1'b0;
            c1_reg <= 1'b0;
            c2_reg <= 1'b0;
        end else begin
            c0_reg <= bus.bus_clk;
            c1_reg <= c0_reg;
            c2_reg <= c1_reg;
        end
    end
    // straps keep sampling in reset, so the release edge sees settled pins
    always_ff @(posedge CLK_SYS_I) begin
        strap0_reg <= STRAP_I;
        strap1_reg <= strap0_reg;
    end
    assign clk_rise = c1_reg & ~c2_reg;
    // ----------------------------------------------
    // power-on configuration
    // ----------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        rst_d_reg <= RSTN_I;
    end
    // loads once, on the first edge after reset is released
    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            CFG_O <= pbap_pkg::CFG_RST;
        end else if (!rst_d_reg) begin
            CFG_O <= strap1_reg;
        end
    end
    // ----------------------------------------------
    // cache lookup address
    // ----------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            lookup_reg <= '0;
        end else begin
            lookup_reg <= mask_a20(ADDR_I, m1_reg);
        end
    end
    assign LOOKUP_ADDR_O = lookup_reg;
    // ----------------------------------------------
    // address phase sequencer
    // ----------------------------------------------
    // one transaction at a time: START_I is ignored while busy
    assign take = (st_reg == ST_IDLE) && START_I;
    assign addr_launch = (st_reg == ST_WAIT) && clk_rise;
    assign type_launch = (st_reg == ST_TYPE) && clk_rise;
    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            st_reg <= ST_IDLE;
        end else begin
            unique case (st_reg)
                ST_IDLE: begin
                    if (take) begin
                        st_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (addr_launch) begin
                        st_reg <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    st_reg <= ST_TYPE;
                end
                ST_TYPE: begin
                    if (type_launch) begin
                        st_reg <= ST_END;
                    end
                end
                ST_END: begin
                    if (clk_rise) begin
                        st_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end
    // ----------------------------------------------
    // request capture
    // ----------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            addr_reg <= '0;
            type_reg <= '0;
            req_reg <= '0;
        end else if (take) begin
            addr_reg <= mask_a20(ADDR_I, m1_reg);
            type_reg <= TYPE_I;
            req_reg <= REQ_I;
        end
    end
    // ----------------------------------------------
    // address lines: address, then type
    // ----------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            aline_reg <= pbap_pkg::ALINE_RST;
        end else if (addr_launch) begin
            aline_reg <= addr_reg[pbap_pkg::ADDR_W-1:
                pbap_pkg::ALINE_LSB];
        end else if (type_launch) begin
            aline_reg <= type_reg;
        end
    end
    // ----------------------------------------------
    // address valid strobe
    // ----------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            ads_reg <= 1'b0;
        end else if (addr_launch) begin
            ads_reg <= 1'b1;
        end else if (st_reg == ST_END && clk_rise) begin
            ads_reg <= 1'b0;
        end
    end
    // ----------------------------------------------
    // address strobes: rise with address, fall with type
    // ----------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            stb_reg <= 2'h0;
        end else if (st_reg == ST_ADDR) begin
            stb_reg <= 2'h3;
        end else if (st_reg == ST_END) begin
            stb_reg <= 2'h0;
        end
    end
    // ----------------------------------------------
    // link and handshake outputs
    // ----------------------------------------------
    assign READY_O = (st_reg == ST_IDLE);
    assign bus.aline = aline_reg;
    assign bus.req = req_reg;
    assign bus.address_valid_strobe = ads_reg;
    assign bus.address_phase_strobes = stb_reg;
endmodule : pbap_requester
